// file: verilog/dmadr_pkg.sv
// shared constants and types for the descriptor ring engine and its host end
package dmadr_pkg;
   localparam int NCH = 13;
   localparam int CHW = 4;
   localparam int HOST_AW = 8;
   localparam int RING_AW = 10;
   localparam int FLG_W = 31;
   localparam int FLG_I = 30;
   localparam int FLG_L = 29;
   localparam int FLG_F = 28;
   localparam int LEN_LO = 16;
   localparam int LENW = 12;
   localparam int STSW = 16;
   localparam logic [1:0] FB_LASTW = 2'h1;
   localparam logic [1:0] CP_LASTW = 2'h2;
   localparam logic [31:0] FB_STRIDE = 32'h0000_0008;
   localparam logic [31:0] CP_STRIDE = 32'h0000_0010;
   localparam logic [31:0] FB_ALIGN = 32'hFFFF_FFF8;
   localparam logic [31:0] CP_ALIGN = 32'hFFFF_FFF0;
   localparam logic [3:0] BE_ALL = 4'hF;
   localparam logic [NCH-1:0] CAN_P2M = 13'h017D;
   localparam logic [NCH-1:0] CAN_M2P = 13'h02BE;
   localparam logic [NCH-1:0] CAN_COPY = 13'h1FFF;
   typedef enum logic [1:0] {
      MD_P2M = 2'h0,
      MD_M2P = 2'h1,
      MD_COPY = 2'h2,
      MD_RSVD = 2'h3
   } dmadr_mode_t;
endpackage

// file: verilog/dmadr_if.sv
`timescale 1ns/1ns
// memory bus and channel control link between engine and host end
interface dmadr_if;
   import dmadr_pkg::*;
   logic mreq;
   logic mwe;
   logic [31:0] maddr;
   logic [3:0] mbe;
   logic [31:0] mwdata;
   logic mack;
   logic [31:0] mrdata;
   logic [NCH-1:0] go;
   logic [NCH-1:0] kick;
   logic [NCH-1:0] nc_ie;
   logic [NCH-1:0] stop_ie;
   logic [NCH-1:0][31:0] dptr;
   dmadr_mode_t [NCH-1:0] mode;
   modport dev (
      output mreq, mwe, maddr, mbe, mwdata,
      input mack, mrdata, go, kick, nc_ie, stop_ie, dptr, mode
   );
   modport oth (
      input mreq, mwe, maddr, mbe, mwdata,
      output mack, mrdata, go, kick, nc_ie, stop_ie, dptr, mode
   );
endinterface

// file: verilog/dmadr_host.sv
`timescale 1ns/1ns
// host end: descriptor and buffer memory plus per-channel control state
module dmadr_host (
   input wire logic mclk, // system clock
   input wire logic arst_n, // asynchronous reset, active low
   dmadr_if.oth bus, // link to the engine
   input wire logic [dmadr_pkg::NCH-1:0] u_go, // channel-go levels
   input wire dmadr_pkg::dmadr_mode_t [dmadr_pkg::NCH-1:0] u_mode, // transfer mode per channel
   input wire logic [dmadr_pkg::NCH-1:0] u_nc_ie, // normal-completion interrupt enables
   input wire logic [dmadr_pkg::NCH-1:0] u_stop_ie, // occupancy-stall interrupt enables
   input wire logic u_pw, // write a descriptor pointer
   input wire logic [dmadr_pkg::CHW-1:0] u_pch, // channel of that pointer
   input wire logic [31:0] u_pval, // pointer value
   input wire logic u_mwe, // software memory write
   input wire logic [dmadr_pkg::HOST_AW-1:0] u_maddr, // word index for software access
   input wire logic [31:0] u_mwdata, // software write data
   output logic [31:0] u_mrdata // software read data, one cycle late
);
   import dmadr_pkg::*;

   typedef struct packed {
      logic [NCH-1:0] go;
      dmadr_mode_t [NCH-1:0] mode;
      logic [NCH-1:0] nci;
      logic [NCH-1:0] sti;
      logic [NCH-1:0][31:0] dptr;
      logic [NCH-1:0] kick;
      logic ack;
      logic [31:0] rd;
      logic [31:0] urd;
   } dmadr_hst_t;

   dmadr_hst_t q;
   dmadr_hst_t n;
   logic [31:0] mem [2**HOST_AW];
   logic [HOST_AW-1:0] widx;
   logic bw;

   assign widx = bus.maddr[HOST_AW+1:2];
   // software owns the memory port in a cycle it writes; the engine waits
   assign bw = bus.mreq && bus.mwe && !q.ack && !u_mwe;

   always_comb begin
      n = q;
      n.go = u_go;
      n.mode = u_mode;
      n.nci = u_nc_ie;
      n.sti = u_stop_ie;
      n.kick = '0;
      n.ack = 1'b0;
      n.urd = mem[u_maddr];
      if (u_pw && u_pch < NCH) begin
         // ring start kept on its descriptor grid
         n.dptr[u_pch] = u_pval & ((u_mode[u_pch] == MD_COPY) ? CP_ALIGN : FB_ALIGN);
      end
      if (u_mwe) begin
         // any write may have changed an occupancy bit: wake every running channel
         n.kick = q.go | u_go;
      end else if (bus.mreq && !q.ack) begin
         n.ack = 1'b1;
         n.rd = mem[widx];
      end
   end

   always_ff @(posedge mclk) begin
      if (u_mwe) begin
         mem[u_maddr] <= u_mwdata;
      end
      for (int b = 0; b < 4; b++) begin
         if (bw && bus.mbe[b]) begin
            mem[widx][8*b +: 8] <= bus.mwdata[8*b +: 8];
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign bus.mack = q.ack;
   assign bus.mrdata = q.rd;
   assign bus.go = q.go;
   assign bus.mode = q.mode;
   assign bus.nc_ie = q.nci;
   assign bus.stop_ie = q.sti;
   assign bus.dptr = q.dptr;
   assign bus.kick = q.kick;
   assign u_mrdata = q.urd;
endmodule // dmadr_host

// file: verilog/dmadr_engine.sv
`timescale 1ns/1ns
// descriptor ring engine: fetches, runs and closes buffer descriptors for 13 channels

// What this block does
// - channel idle until go, then fetch pointer
// - fly-by two words, copy three, aligned
// - no wrap mark: next descriptor follows current
// - wrap mark: return to ring start
// - no mark: wrap at 1024-byte boundary
// - ring holds 128 fly-by, 64 copy
// - close with alert bit always interrupts
// - frame-end mark signals frame end outward in fly-by modes only
// - fill only empty, empty only full buffers
// - software kicks channel after changing occupancy
// - blocked by occupancy bit: maskable interrupt
// - copy starts only when occupancy bit set
// - receive buffers word aligned, transmit any byte; receive writes take any byte address too
// - peripheral status written back on fly-by close
// - receive: length is capacity, then received count
// - transmit: length moved, then count written back
// - copy: length moved, remaining count written back
// - unequal alignment needs byte-wide operands
// - copy on all channels, fly-by only assigned
// - fixed peripheral direction on channels 0, 1 and 6 to 9; 2 to 5 take either, 10 to 12 none
// - channels 2 to 5 serve external handshakes
// - mode codes: receive, transmit, copy, reserved
// - copy holds each datum in temporary register
module dmadr_engine (
   input wire logic mclk, // system clock
   input wire logic arst_n, // asynchronous reset, active low
   dmadr_if.dev bus, // memory bus and channel control
   output logic tx_valid, // byte to peripheral valid
   input wire logic tx_ready, // peripheral takes the byte
   output logic [7:0] tx_data, // byte to peripheral
   output logic tx_last, // byte closes a message frame
   output logic [dmadr_pkg::CHW-1:0] tx_ch, // channel of that byte
   input wire logic rx_valid, // byte from peripheral valid
   output logic rx_ready, // engine takes the byte
   input wire logic [7:0] rx_data, // byte from peripheral
   input wire logic rx_end, // byte ends the received message
   output logic [dmadr_pkg::CHW-1:0] rx_ch, // channel being served
   input wire logic [15:0] pstat, // peripheral status word
   output logic frame_end, // pulse: frame-end buffer closed
   output logic irq, // pulse: interrupt event
   output logic irq_stall, // event was an occupancy or mode stall
   output logic [dmadr_pkg::CHW-1:0] irq_ch, // channel of the event
   output logic [dmadr_pkg::NCH-1:0] parked // channels waiting for a kick
);
   import dmadr_pkg::*;

   typedef enum logic [3:0] {S_IDLE, S_DRD, S_CHK, S_SRC, S_DST, S_RX, S_WB, S_NEXT} dmadr_st_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [31:0] a;
      logic [3:0] be;
      logic [31:0] d;
   } dmadr_acc_t;

   typedef struct packed {
      dmadr_st_t st;
      logic [CHW-1:0] ch;
      logic [1:0] wi;
      logic [NCH-1:0] park;
      logic [NCH-1:0][31:0] cur;
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] w2;
      logic [31:0] adr;
      logic [LENW-1:0] cnt;
      logic [7:0] tmp;
      logic rend;
      dmadr_acc_t m;
      logic rxr;
      logic irq;
      logic stall;
      logic [CHW-1:0] ich;
      logic fe;
      logic ov;
      logic [CHW+8:0] od;
      logic sv;
      logic [CHW+8:0] sd;
   } dmadr_dev_t;

   dmadr_dev_t q;
   dmadr_dev_t n;
   dmadr_mode_t md;
   logic ack;
   logic [31:0] flw;
   logic [LENW-1:0] len;
   logic [LENW-1:0] wlen;
   logic [1:0] lastw;
   logic [7:0] byt;
   logic [31:0] src_a;
   logic [31:0] dst_a;
   logic [31:0] nx;
   logic [31:0] wbw;
   logic [CHW+8:0] ent;
   logic [CHW:0] pk;

   function automatic dmadr_acc_t acc(input logic we, input logic [31:0] a, input logic [3:0] be,
                                      input logic [31:0] d);
      acc = '{req: 1'b1, we: we, a: a, be: be, d: d};
   endfunction

   // single-byte lane; every datum moves a byte at a time, so any alignment works
   function automatic logic [3:0] lane_be(input logic [1:0] a);
      lane_be = 4'h1 << a;
   endfunction

   function automatic logic mode_ok(input dmadr_mode_t m, input logic [CHW-1:0] c);
      case (m)
         MD_P2M: mode_ok = CAN_P2M[c];
         MD_M2P: mode_ok = CAN_M2P[c];
         MD_COPY: mode_ok = CAN_COPY[c];
         default: mode_ok = 1'b0;
      endcase
   endfunction

   // round robin: first ready channel after the last one served
   function automatic logic [CHW:0] pick(input logic [NCH-1:0] r, input logic [CHW-1:0] last);
      int j;
      pick = '0;
      for (int i = NCH; i >= 1; i--) begin
         j = (int'(last) + i) % NCH;
         if (r[j]) begin
            pick = {1'b1, CHW'(j)};
         end
      end
   endfunction

   assign md = bus.mode[q.ch];
   assign ack = q.m.req && bus.mack;
   assign lastw = (md == MD_COPY) ? CP_LASTW : FB_LASTW;
   assign flw = (md == MD_COPY) ? q.w2 : q.w1;
   assign len = flw[LEN_LO +: LENW];
   assign src_a = q.w0 + {20'h0, q.cnt};
   assign dst_a = q.w1 + {20'h0, q.cnt};
   assign byt = 8'(bus.mrdata >> {q.m.a[1:0], 3'h0});
   assign nx = q.adr + ((md == MD_COPY) ? CP_STRIDE : FB_STRIDE);
   assign ent = {q.ch, flw[FLG_L] && (q.cnt + 12'h1 == len), byt};
   assign wlen = (md == MD_COPY) ? len - q.cnt : q.cnt;
   assign wbw = {flw[FLG_W], flw[FLG_I], flw[FLG_L], md == MD_P2M, wlen,
                 (md == MD_COPY) ? flw[STSW-1:0] : pstat};
   assign pk = pick(bus.go & ~q.park, q.ch);

   always_comb begin
      n = q;
      n.irq = 1'b0;
      n.fe = 1'b0;
      if (ack) begin
         n.m.req = 1'b0;
      end
      if (q.ov && tx_ready) begin
         n.ov = q.sv;
         n.od = q.sd;
         n.sv = 1'b0;
      end
      // kick clears the park first so a stall found this cycle still wins
      for (int i = 0; i < NCH; i++) begin
         if (!bus.go[i] || bus.kick[i]) begin
            n.park[i] = 1'b0;
         end
      end
      case (q.st)
         S_IDLE: begin
            if (pk[CHW]) begin
               n.ch = pk[CHW-1:0];
               n.adr = q.cur[pk[CHW-1:0]];
               n.wi = 2'h0;
               n.m = acc(1'b0, q.cur[pk[CHW-1:0]], BE_ALL, 32'h0);
               n.st = S_DRD;
            end
         end
         S_DRD: begin
            if (ack) begin
               case (q.wi)
                  2'h0: n.w0 = bus.mrdata;
                  2'h1: n.w1 = bus.mrdata;
                  default: n.w2 = bus.mrdata;
               endcase
               if (q.wi == lastw) begin
                  n.st = S_CHK;
               end else begin
                  n.wi = q.wi + 2'h1;
                  n.m = acc(1'b0, q.adr + {28'h0, q.wi + 2'h1, 2'h0}, BE_ALL, 32'h0);
               end
            end
         end
         S_CHK: begin
            n.cnt = '0;
            n.rend = 1'b0;
            n.ich = q.ch;
            // fill needs empty, drain and copy need full; bad mode parks too
            if (!mode_ok(md, q.ch) || ((md == MD_P2M) == flw[FLG_F])) begin
               n.park[q.ch] = 1'b1;
               n.irq = bus.stop_ie[q.ch];
               n.stall = 1'b1;
               n.st = S_IDLE;
            end else begin
               n.st = (md == MD_P2M) ? S_RX : S_SRC;
            end
         end
         S_SRC: begin
            if (q.m.req) begin
               if (ack && md == MD_COPY) begin
                  n.tmp = byt;
                  n.st = S_DST;
               end else if (ack) begin
                  if (!n.ov) begin
                     n.ov = 1'b1;
                     n.od = ent;
                  end else begin
                     n.sv = 1'b1;
                     n.sd = ent;
                  end
                  n.cnt = q.cnt + 12'h1;
               end
            end else if (q.cnt == len) begin
               n.st = S_WB;
            end else if (md == MD_COPY || !q.sv) begin
               // a read is only issued while the buffer has room for its byte
               n.m = acc(1'b0, src_a, lane_be(src_a[1:0]), 32'h0);
            end
         end
         S_DST: begin
            if (q.m.req) begin
               if (ack) begin
                  n.cnt = q.cnt + 12'h1;
                  n.st = S_SRC;
               end
            end else begin
               n.m = acc(1'b1, dst_a, lane_be(dst_a[1:0]), {4{q.tmp}});
            end
         end
         S_RX: begin
            if (q.m.req) begin
               if (ack) begin
                  n.cnt = q.cnt + 12'h1;
                  if (q.rend) begin
                     n.st = S_WB;
                  end
               end
            end else if (q.rxr) begin
               if (rx_valid) begin
                  n.rxr = 1'b0;
                  n.rend = rx_end;
                  n.m = acc(1'b1, src_a, lane_be(src_a[1:0]), {4{rx_data}});
               end
            end else if (q.cnt == len) begin
               n.st = S_WB;
            end else begin
               n.rxr = 1'b1;
            end
         end
         S_WB: begin
            if (q.m.req) begin
               if (ack) begin
                  n.st = S_NEXT;
               end
            end else begin
               n.m = acc(1'b1, q.adr + {28'h0, lastw, 2'h0}, BE_ALL, wbw);
            end
         end
         S_NEXT: begin
            n.irq = flw[FLG_I] || bus.nc_ie[q.ch];
            n.stall = 1'b0;
            n.ich = q.ch;
            n.fe = flw[FLG_L] && (md != MD_COPY);
            // the 1 KiB ring bounds a ring to 128 or 64 descriptors
            if (flw[FLG_W] || nx[RING_AW-1:0] == '0) begin
               n.cur[q.ch] = bus.dptr[q.ch];
            end else begin
               n.cur[q.ch] = nx;
            end
            n.st = S_IDLE;
         end
         default: n.st = S_IDLE;
      endcase
      for (int i = 0; i < NCH; i++) begin
         if (!bus.go[i]) begin
            n.cur[i] = bus.dptr[i];
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign bus.mreq = q.m.req;
   assign bus.mwe = q.m.we;
   assign bus.maddr = q.m.a;
   assign bus.mbe = q.m.be;
   assign bus.mwdata = q.m.d;
   assign tx_valid = q.ov;
   assign tx_data = q.od[7:0];
   assign tx_last = q.od[8];
   assign tx_ch = q.od[CHW+8:9];
   assign rx_ready = q.rxr;
   assign rx_ch = q.ch;
   assign frame_end = q.fe;
   assign irq = q.irq;
   assign irq_stall = q.stall;
   assign irq_ch = q.ich;
   assign parked = q.park;
endmodule // dmadr_engine

// file: bench/dmadr_link_properties.sv
// concurrent checks on the link between engine and host end
`timescale 1ns/1ns
module dmadr_link_properties (
   input wire logic mclk, // system clock
   input wire logic arst_n, // reset, active low
   input wire logic mreq, // memory request
   input wire logic mwe, // write strobe
   input wire logic [31:0] maddr, // byte address
   input wire logic [3:0] mbe, // byte enables
   input wire logic [31:0] mwdata, // write data
   input wire logic mack, // answer
   input wire logic [31:0] mrdata, // read data
   input wire logic [dmadr_pkg::NCH-1:0] go, // channel-go
   input wire logic [dmadr_pkg::NCH-1:0] kick, // reactivation pulses
   input wire logic [dmadr_pkg::NCH-1:0] nc_ie, // completion enables
   input wire logic [dmadr_pkg::NCH-1:0] stop_ie, // stall enables
   input wire logic [dmadr_pkg::NCH-1:0][31:0] dptr, // ring starts
   input wire dmadr_pkg::dmadr_mode_t [dmadr_pkg::NCH-1:0] mode // modes
);
   import dmadr_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   logic [31:0] g_ptr;
   dmadr_mode_t g_mode;
   logic [31:0] nxt_q;
   logic [31:0] nxt_w;
   logic close_w;
   assign close_w = mreq && mack && mwe && (mbe == BE_ALL);
   assign nxt_w = maddr + ((g_mode == MD_COPY) ? 32'h8 : 32'h4);
   // only meaningful while a single channel has go set
   always_comb begin
      g_ptr = 32'h0;
      g_mode = MD_P2M;
      for (int i = 0; i < NCH; i++) begin
         if (go[i]) begin
            g_ptr = dptr[i];
            g_mode = mode[i];
         end
      end
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         nxt_q <= 32'h0;
      end else if (close_w) begin
         // unmarked ring still wraps when the next slot falls on the 1 KiB boundary
         nxt_q <= (mwdata[FLG_W] || nxt_w[RING_AW-1:0] == '0) ? g_ptr : nxt_w;
      end
   end
   hold_req_a: assert property (mreq && !mack |=> mreq && $stable(maddr) && $stable(mwe)
      && $stable(mbe) && $stable(mwdata)) else $error("request changed before answer");
   ack_pulse_a: assert property (mack |-> $past(mreq) && !$past(mack))
      else $error("answer without request");
   idle_quiet_a: assert property ((go == '0 && !mreq) [*4] |=> !mreq)
      else $error("fetch without channel-go");
   first_fetch_a: assert property ($past(go) == '0 && $onehot(go) |-> ##[1:4] (mreq && !mwe && maddr == g_ptr))
      else $error("first fetch not at ring start");
   desc_word_a: assert property (mreq && mbe == BE_ALL |-> maddr[1:0] == 2'h0 && maddr[31:10] == g_ptr[31:10])
      else $error("descriptor access outside ring");
   close_slot_a: assert property (mreq && mwe && mbe == BE_ALL |-> (g_mode == MD_COPY && maddr[3:0] == 4'h8)
      || (g_mode != MD_COPY && maddr[2:0] == 3'h4)) else $error("close write at wrong word");
   full_flag_a: assert property (close_w |-> mwdata[FLG_F] == (g_mode == MD_P2M))
      else $error("occupancy bit wrong on close");
   copy_left_a: assert property (close_w && g_mode == MD_COPY |-> mwdata[27:16] == 12'h0)
      else $error("copy remaining count wrong");
   byte_lane_a: assert property (mreq && mwe && mbe != BE_ALL |-> $onehot(mbe)
      && mwdata[31:24] == mwdata[7:0] && mwdata[15:8] == mwdata[7:0]) else $error("byte write malformed");
   next_desc_a: assert property (close_w |=> ##[0:30] (mreq && !mwe && maddr == nxt_q))
      else $error("next descriptor address wrong");
   cover property (close_w);
   cover property (kick != '0);
   cover property (mreq && mwe && mbe != BE_ALL && mack);
   cover property (close_w && nc_ie != '0);
endmodule // dmadr_link_properties

// file: bench/tb_top.sv
// self-checking bench: engine and host end joined by the link
`timescale 1ns/1ns
module tb_top;
   import dmadr_pkg::*;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [NCH-1:0] u_go = '0;
   dmadr_mode_t [NCH-1:0] u_mode = '{default: MD_P2M};
   logic [NCH-1:0] u_stop_ie = '1;
   logic [NCH-1:0] u_nc_ie = '0;
   logic u_pw = 1'b0;
   logic [CHW-1:0] u_pch = '0;
   logic [31:0] u_pval = '0;
   logic u_mwe = 1'b0;
   logic [HOST_AW-1:0] u_maddr = '0;
   logic [31:0] u_mwdata = '0;
   logic [31:0] u_mrdata;
   logic tx_valid, tx_last, rx_ready, frame_end, irq, irq_stall;
   logic tx_ready = 1'b0;
   logic rx_valid = 1'b0;
   logic rx_end = 1'b0;
   logic [7:0] tx_data;
   logic [7:0] rx_data = '0;
   logic [CHW-1:0] tx_ch, rx_ch, irq_ch, last_ch;
   logic [15:0] pstat = 16'hA5C3;
   logic [NCH-1:0] parked;
   logic [31:0] rd;
   int n_errors = 0, cmp_count = 0, n_irq = 0, n_stall = 0, n_fe = 0, cyc = 0;
   dmadr_if link ();
   dmadr_host dmadr_host_i (.mclk(mclk), .arst_n(arst_n), .bus(link), .u_go(u_go), .u_mode(u_mode),
      .u_nc_ie(u_nc_ie), .u_stop_ie(u_stop_ie), .u_pw(u_pw), .u_pch(u_pch), .u_pval(u_pval), .u_mwe(u_mwe),
      .u_maddr(u_maddr), .u_mwdata(u_mwdata), .u_mrdata(u_mrdata));
   dmadr_engine dmadr_engine_i (.mclk(mclk), .arst_n(arst_n), .bus(link), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .tx_last(tx_last), .tx_ch(tx_ch), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .rx_end(rx_end), .rx_ch(rx_ch), .pstat(pstat), .frame_end(frame_end), .irq(irq), .irq_stall(irq_stall),
      .irq_ch(irq_ch), .parked(parked));
   dmadr_link_properties dmadr_link_properties_i (.mclk(mclk), .arst_n(arst_n), .mreq(link.mreq), .mwe(link.mwe),
      .maddr(link.maddr), .mbe(link.mbe), .mwdata(link.mwdata), .mack(link.mack), .mrdata(link.mrdata),
      .go(link.go), .kick(link.kick), .nc_ie(link.nc_ie), .stop_ie(link.stop_ie), .dptr(link.dptr), .mode(link.mode));
   always #5 mclk = ~mclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("errors=%0d compares=%0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // interrupt and frame events are counted here, so tasks only compare totals and last_ch
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (irq === 1'b1) begin
         n_irq <= n_irq + 1;
         n_stall <= n_stall + (irq_stall === 1'b1);
         last_ch <= irq_ch;
      end
      if (frame_end === 1'b1) begin
         n_fe <= n_fe + 1;
      end
      if (cyc == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   function automatic logic [31:0] fw(input logic w, i, l, f, input logic [11:0] len, input logic [15:0] st);
      return {w, i, l, f, len, st};
   endfunction
   task automatic mem_wr(input logic [HOST_AW-1:0] a, input logic [31:0] d);
      @(posedge mclk);
      u_mwe <= 1'b1;
      u_maddr <= a;
      u_mwdata <= d;
      @(posedge mclk);
      u_mwe <= 1'b0;
   endtask
   task automatic mem_rd(input logic [HOST_AW-1:0] a);
      @(posedge mclk);
      u_maddr <= a;
      @(posedge mclk);
      @(posedge mclk);
      rd = u_mrdata;
   endtask
   task automatic start(input int ch, input dmadr_mode_t m, input logic [31:0] p);
      @(posedge mclk);
      u_pw <= 1'b1;
      u_pch <= CHW'(ch);
      u_pval <= p;
      u_mode[ch] <= m;
      @(posedge mclk);
      u_pw <= 1'b0;
      @(posedge mclk);
      u_go[ch] <= 1'b1;
   endtask
   task automatic wait_irq(input int want);
      for (int k = 0; k < 400 && n_irq < want; k++) begin
         @(posedge mclk);
      end
      check(n_irq, want);
   endtask
   task automatic rx_send(input logic [7:0] d, input logic e);
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_data <= d;
      rx_end <= e;
      do @(posedge mclk); while (rx_ready !== 1'b1);
      check(rx_ch, 4'h0);
      rx_valid <= 1'b0;
   endtask
   task automatic tx_case();
      logic [7:0] exp [3] = '{8'h22, 8'h33, 8'h44};
      mem_wr(8'h00, 32'h0000_0201);
      mem_wr(8'h01, fw(1, 1, 1, 1, 12'h003, 16'h0000));
      mem_wr(8'h80, 32'h4433_2211);
      start(1, MD_M2P, 32'h0);
      repeat (40) @(posedge mclk);
      check(tx_valid, 1'b1);
      tx_ready <= 1'b1;
      for (int b = 0; b < 3; b++) begin
         do @(posedge mclk); while (tx_valid !== 1'b1);
         check(tx_data, exp[b]);
         check(tx_last, b == 2);
         check(tx_ch, 4'h1);
      end
      wait_irq(1);
      check(n_fe, 1);
      wait_irq(2);
      check(n_stall, 1);
      check(last_ch, 4'h1);
      check(parked[1], 1'b1);
      mem_rd(8'h01);
      check(rd, fw(1, 1, 1, 0, 12'h003, 16'hA5C3));
      u_go[1] <= 1'b0;
   endtask
   task automatic rx_case();
      // no wrap mark anywhere: the ring must wrap at the 1 KiB boundary
      mem_wr(8'hFC, 32'h0000_0240);
      mem_wr(8'hFD, fw(0, 0, 0, 0, 12'h008, 16'h0000));
      mem_wr(8'hFE, 32'h0000_0260);
      mem_wr(8'hFF, fw(0, 0, 1, 0, 12'h008, 16'h0000));
      mem_wr(8'h90, 32'h0);
      mem_wr(8'h98, 32'h0);
      pstat <= 16'h0F1E;
      u_nc_ie[0] <= 1'b1;
      start(0, MD_P2M, 32'h3F0);
      rx_send(8'hAB, 1'b0);
      rx_send(8'hCD, 1'b0);
      rx_send(8'hEF, 1'b1);
      rx_send(8'h5A, 1'b1);
      wait_irq(5);
      check(n_stall, 2);
      check(parked[0], 1'b1);
      check(n_fe, 2);
      mem_rd(8'hFD);
      check(rd, fw(0, 0, 0, 1, 12'h003, 16'h0F1E));
      mem_rd(8'hFF);
      check(rd, fw(0, 0, 1, 1, 12'h001, 16'h0F1E));
      mem_rd(8'h90);
      check(rd, 32'h00EF_CDAB);
      mem_rd(8'h98);
      check(rd, 32'h0000_005A);
      u_go[0] <= 1'b0;
      u_nc_ie[0] <= 1'b0;
   endtask
   task automatic copy_case();
      mem_wr(8'h60, 32'h0000_02C0);
      mem_wr(8'h61, 32'h0000_02E0);
      mem_wr(8'h62, fw(1, 1, 0, 0, 12'h004, 16'h1234));
      mem_wr(8'hB0, 32'hC3B2_A190);
      mem_wr(8'hB8, 32'h0);
      start(11, MD_COPY, 32'h180);
      wait_irq(6);
      check(parked[11], 1'b1);
      mem_rd(8'hB8);
      check(rd, 32'h0);
      // this write also kicks the parked channel
      mem_wr(8'h62, fw(1, 1, 0, 1, 12'h004, 16'h1234));
      wait_irq(8);
      check(n_stall, 4);
      mem_rd(8'hB8);
      check(rd, 32'hC3B2_A190);
      mem_rd(8'h62);
      check(rd, fw(1, 1, 0, 0, 12'h000, 16'h1234));
      u_go[11] <= 1'b0;
   endtask
   task automatic stall_case();
      for (int j = 0; j < 2; j++) begin
         repeat (3) @(posedge mclk);
         mem_wr(j ? 8'h68 : 8'h70, 32'h0000_0300);
         mem_wr(j ? 8'h69 : 8'h71, fw(1, 0, 0, 1, 12'h001, 16'h0000));
         start(j ? 10 : 12, j ? MD_M2P : MD_RSVD, j ? 32'h1A0 : 32'h1C0);
         wait_irq(9 + j);
         check(n_stall, 5 + j);
         check(last_ch, j ? 4'hA : 4'hC);
         u_go[j ? 10 : 12] <= 1'b0;
      end
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      tx_case();
      rx_case();
      copy_case();
      stall_case();
      complete_run();
   end
endmodule // tb_top
